// ===== core/aout_map.svh
// Register offsets, reset values and level constants of the analogue output setpoint block.
// Assumes byte addresses on a 32-bit classic Wishbone bus, one aligned word per register.
`ifndef AOUT_MAP_SVH
`define AOUT_MAP_SVH
`define A_CTRL     8'h00
`define A_IN_LO    8'h04
`define A_IN_HI    8'h08
`define A_EXT      8'h0C
`define A_TIMEOUT  8'h10
`define A_REMOTE   8'h14
`define A_STATUS   8'h18
`define A_MASK     8'h1C
`define A_SETPT    8'h20
`define RST_CTRL   32'h0000_0000
`define RST_IN_LO  16'h0000
`define RST_IN_HI  16'h03E8
`define RST_EXT    32'h0000_0000
`define RST_TMO    7'h00
`define RST_REMOTE 16'h0000
`define RST_MASK   4'h0
`define RST_STATUS 4'h0
`define SECS_SAT   7'h7F
`define ST_CLAMP_LO 0
`define ST_CLAMP_HI 1
`define ST_FAULT_IN 2
`define ST_LINK_TMO 3
// Levels in uA for current and mV for voltage
`define LVL_0      16'h0000
`define LVL_4MA    16'h0FA0
`define LVL_20MA   16'h4E20
`define LVL_1V     16'h03E8
`define LVL_2V     16'h07D0
`define LVL_5V     16'h1388
`define LVL_10V    16'h2710
`define LVL_22M1A  16'h5654
`define LVL_3M4A   16'h0D48
`define LVL_11V    16'h2AF8
`define LVL_5V5    16'h157C
`define LVL_1V2    16'h04B0
`define LVL_0V6    16'h0258
// Extension limits in 0.1 percent steps
`define EXT_LO_ACT 10'h3E7
`define EXT_LO_PAS 10'h12B
`define EXT_HI_I   10'h0C7
`define EXT_HI_V   10'h063
`define PERMILLE   32'h0000_03E8
`define TMO_MAX_S  7'h63
`define SEC_NS     32'h3B9A_CA00
`define CLK_NS     32'h0000_0014
`endif

// ===== core/aout_pkg.sv
// Types shared by the analogue output setpoint block.
// Assumes the map header supplies the register offsets and levels; the field and state codes are fixed here.
package aout_pkg;
	typedef enum logic [1:0] {KIND_ACT_I = 2'h0, KIND_PAS_I = 2'h1, KIND_ACT_V = 2'h2, KIND_RSV = 2'h3} out_kind_t;
	typedef enum logic [2:0] {
		MODE_OFF = 3'h0, MODE_I0_20 = 3'h1, MODE_I4_20 = 3'h2, MODE_V0_5 = 3'h3,
		MODE_V1_5 = 3'h4, MODE_V0_10 = 3'h5, MODE_V2_10 = 3'h6, MODE_LINK = 3'h7
	} out_mode_t;
	typedef enum logic [2:0] {
		FLT_HOLD = 3'h0, FLT_HIGH = 3'h1, FLT_MID = 3'h2, FLT_LOW2 = 3'h3,
		FLT_LOW1 = 3'h4, FLT_ZERO = 3'h5, FLT_RSV6 = 3'h6, FLT_RSV7 = 3'h7
	} out_fault_t;
	typedef struct packed {
		logic [22:0] rsv;
		logic        src_peak;
		out_fault_t  fault;
		out_mode_t   mode;
		out_kind_t   kind;
	} ctrl_t;
	typedef struct packed {
		logic [5:0] rsv1;
		logic [9:0] hi;
		logic [5:0] rsv0;
		logic [9:0] lo;
	} ext_t;
	typedef enum logic [2:0] {ST_OFF = 3'b001, ST_RUN = 3'b010, ST_FAULT = 3'b100} run_state_t;
endpackage : aout_pkg

// ===== core/analog_output_setpoint_control.sv
// Analogue output setpoint: maps the displayed or held value onto the selected span, clamps, applies fault levels.
// Assumes value, critical and frame inputs come from logic on clk_i; registers over classic Wishbone.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "aout_map.svh"

module analog_output_setpoint_control #(
	parameter int unsigned SEC_CYCLES = `SEC_NS / `CLK_NS
) (
	input  wire logic               clk_i,        // System clock, 50 MHz
	input  wire logic               rst_i,        // Synchronous reset, active high
	input  wire logic               wb_cyc_i,     // Wishbone cycle
	input  wire logic               wb_stb_i,     // Wishbone strobe
	input  wire logic               wb_we_i,      // Wishbone write enable
	input  wire logic        [7:0]  wb_adr_i,     // Byte address
	input  wire logic        [3:0]  wb_sel_i,     // Byte enables
	input  wire logic        [31:0] wb_dat_i,     // Write data
	output logic             [31:0] wb_dat_o,     // Read data
	output logic                    wb_ack_o,     // Acknowledge
	input  wire logic signed [15:0] live_value_i, // Displayed live value
	input  wire logic signed [15:0] peak_value_i, // Held peak or drop value
	input  wire logic               critical_i,   // Critical situation level
	input  wire logic               frame_rx_i,   // Serial frame received pulse
	output logic             [15:0] setpoint_o,   // Output stage setpoint, uA or mV
	output logic                    out_en_o,     // Output stage enabled
	output logic                    fault_o,      // Fault level applied
	output logic                    irq_o         // Interrupt, active high level
);
	localparam int CW = $clog2(SEC_CYCLES);

	aout_pkg::ctrl_t       ctrl_q;
	aout_pkg::ext_t        ext_q;
	aout_pkg::run_state_t  st_q;
	aout_pkg::run_state_t  st_d;
	logic signed [15:0] in_lo_q;
	logic signed [15:0] in_hi_q;
	logic        [6:0]  tmo_q;
	logic        [15:0] remote_q;
	logic        [3:0]  status_q;
	logic        [3:0]  mask_q;
	logic        [15:0] setpoint_d;
	logic        [CW-1:0] pre_q;
	logic        [6:0]  secs_q;
	logic               lost_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Address hits, shared by the write strobes and the read mux
	wire hit_ctrl = wb_adr_i == `A_CTRL;
	wire hit_lo   = wb_adr_i == `A_IN_LO;
	wire hit_hi   = wb_adr_i == `A_IN_HI;
	wire hit_ext  = wb_adr_i == `A_EXT;
	wire hit_tmo  = wb_adr_i == `A_TIMEOUT;
	wire hit_rem  = wb_adr_i == `A_REMOTE;
	wire hit_stat = wb_adr_i == `A_STATUS;
	wire hit_mask = wb_adr_i == `A_MASK;
	wire hit_setp = wb_adr_i == `A_SETPT;

	// Bus decode
	wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr       = req & wb_we_i;
	wire rd       = req & ~wb_we_i;
	wire wr_ctrl  = wr & hit_ctrl;
	wire wr_lo    = wr & hit_lo;
	wire wr_hi    = wr & hit_hi;
	wire wr_ext   = wr & hit_ext;
	wire wr_tmo   = wr & hit_tmo;
	wire wr_rem   = wr & hit_rem;
	wire wr_mask  = wr & hit_mask;
	wire rd_stat  = rd & hit_stat;

	wire [31:0] ctrl_m = merge(ctrl_q, wb_dat_i, wb_sel_i);
	wire [31:0] ext_m  = merge(ext_q, wb_dat_i, wb_sel_i);
	wire [31:0] lo_m   = merge({16'h0000, in_lo_q}, wb_dat_i, wb_sel_i);
	wire [31:0] hi_m   = merge({16'h0000, in_hi_q}, wb_dat_i, wb_sel_i);
	wire [31:0] tmo_m  = merge({25'h0000000, tmo_q}, wb_dat_i, wb_sel_i);
	wire [31:0] rem_m  = merge({16'h0000, remote_q}, wb_dat_i, wb_sel_i);
	wire [31:0] mask_m = merge({28'h0000000, mask_q}, wb_dat_i, wb_sel_i);

	// Write values; reserved bits are never stored
	wire [31:0] ctrl_wr = {23'h0, ctrl_m[8:0]};
	wire [31:0] ext_wr  = {6'h00, ext_m[25:16], 6'h00, ext_m[9:0]};
	wire [6:0]  tmo_wr  = (tmo_m[6:0] > `TMO_MAX_S) ? `TMO_MAX_S : tmo_m[6:0];

	// Read mux; unmapped words read zero
	wire [31:0] rd_mux =
		hit_ctrl ? {23'h0, ctrl_q[8:0]} :
		hit_lo   ? {16'h0000, in_lo_q} :
		hit_hi   ? {16'h0000, in_hi_q} :
		hit_ext  ? {6'h00, ext_q.hi, 6'h00, ext_q.lo} :
		hit_tmo  ? {25'h0000000, tmo_q} :
		hit_rem  ? {16'h0000, remote_q} :
		hit_stat ? {28'h0000000, status_q} :
		hit_mask ? {28'h0000000, mask_q} :
		hit_setp ? {16'h0000, setpoint_o} :
		32'h0000_0000;

	// Mode availability depends on the fitted output kind
	wire kind_cur = (ctrl_q.kind == aout_pkg::KIND_ACT_I) | (ctrl_q.kind == aout_pkg::KIND_PAS_I);
	wire kind_act = ctrl_q.kind == aout_pkg::KIND_ACT_I;
	wire kind_pas = ctrl_q.kind == aout_pkg::KIND_PAS_I;
	wire kind_v   = ctrl_q.kind == aout_pkg::KIND_ACT_V;
	wire m_volt   = (ctrl_q.mode >= aout_pkg::MODE_V0_5) & (ctrl_q.mode <= aout_pkg::MODE_V2_10);
	wire mode_ok  =
		(ctrl_q.mode == aout_pkg::MODE_OFF) |
		((ctrl_q.mode == aout_pkg::MODE_LINK) & (kind_cur | kind_v)) |
		((ctrl_q.mode == aout_pkg::MODE_I0_20) & kind_act) |
		((ctrl_q.mode == aout_pkg::MODE_I4_20) & kind_cur) |
		(m_volt & kind_v);
	// Unavailable selections fall back to disabled
	wire aout_pkg::out_mode_t mode = mode_ok ? ctrl_q.mode : aout_pkg::MODE_OFF;

	// Span limits A and B
	wire [15:0] span_b =
		((mode == aout_pkg::MODE_V0_5) | (mode == aout_pkg::MODE_V1_5)) ? `LVL_5V :
		((mode == aout_pkg::MODE_V0_10) | (mode == aout_pkg::MODE_V2_10)) ? `LVL_10V :
		`LVL_20MA;
	wire [15:0] span_a =
		(mode == aout_pkg::MODE_I4_20) ? `LVL_4MA :
		(mode == aout_pkg::MODE_V1_5)  ? `LVL_1V :
		(mode == aout_pkg::MODE_V2_10) ? `LVL_2V :
		`LVL_0;

	// Extensions limited by kind on use, so a later kind change cannot widen them
	wire [9:0] lo_lim = kind_pas ? `EXT_LO_PAS : `EXT_LO_ACT;
	wire [9:0] hi_lim = kind_v ? `EXT_HI_V : `EXT_HI_I;
	wire [9:0] lo_pm  = (ext_q.lo > lo_lim) ? lo_lim : ext_q.lo;
	wire [9:0] hi_pm  = (ext_q.hi > hi_lim) ? hi_lim : ext_q.hi;
	wire [31:0] a_ext = ({16'h0000, span_a} * {22'h000000, lo_pm}) / `PERMILLE;
	wire [31:0] b_ext = ({16'h0000, span_b} * {22'h000000, hi_pm}) / `PERMILLE;
	wire [15:0] bord_lo = span_a - a_ext[15:0];
	wire [15:0] bord_hi = span_b + b_ext[15:0];

	// Linear map; a negative denominator inverts the characteristic
	wire signed [15:0] w_val = ctrl_q.src_peak ? peak_value_i : live_value_i;
	wire signed [34:0] diff  = 35'(w_val) - 35'(in_lo_q);
	wire signed [34:0] den   = 35'(in_hi_q) - 35'(in_lo_q);
	wire signed [34:0] width = 35'(signed'({1'b0, span_b})) - 35'(signed'({1'b0, span_a}));
	wire signed [34:0] num   = 35'(diff * width);
	// Equal points would divide by zero; the output then rests at A
	wire signed [34:0] quo   = (den == 35'sh0) ? 35'sh0 : num / den;
	wire signed [34:0] raw   = quo + 35'(signed'({1'b0, span_a}));
	wire below = raw < 35'(signed'({1'b0, bord_lo}));
	wire above = raw > 35'(signed'({1'b0, bord_hi}));
	wire [15:0] mapped = below ? bord_lo : above ? bord_hi : raw[15:0];

	// Fault levels by kind; unavailable codes hold the present level
	wire [15:0] flt_i =
		(ctrl_q.fault == aout_pkg::FLT_HIGH) ? `LVL_22M1A :
		(ctrl_q.fault == aout_pkg::FLT_MID)  ? `LVL_3M4A :
		`LVL_0;
	wire [15:0] flt_v =
		(ctrl_q.fault == aout_pkg::FLT_HIGH) ? `LVL_11V :
		(ctrl_q.fault == aout_pkg::FLT_MID)  ? `LVL_5V5 :
		(ctrl_q.fault == aout_pkg::FLT_LOW2) ? `LVL_1V2 :
		(ctrl_q.fault == aout_pkg::FLT_LOW1) ? `LVL_0V6 :
		`LVL_0;
	wire flt_use_i = (ctrl_q.fault == aout_pkg::FLT_HIGH) | (ctrl_q.fault == aout_pkg::FLT_MID) |
		((ctrl_q.fault == aout_pkg::FLT_ZERO) & kind_act);
	wire flt_use_v = (ctrl_q.fault != aout_pkg::FLT_HOLD) & (ctrl_q.fault <= aout_pkg::FLT_ZERO);
	wire flt_new   = kind_v ? flt_use_v : flt_use_i;
	wire [15:0] flt_lvl = ~flt_new ? setpoint_o : kind_v ? flt_v : flt_i;

	// Frame gap supervision
	wire sec_tick  = pre_q == CW'(SEC_CYCLES - 1);
	wire lost      = (tmo_q != `RST_TMO) & (secs_q >= tmo_q);
	wire link_mode = mode == aout_pkg::MODE_LINK;
	wire fault_req = critical_i | (link_mode & lost);

	// Run state
	always_comb begin
		if (mode == aout_pkg::MODE_OFF) begin
			st_d = aout_pkg::ST_OFF;
		end else if (fault_req) begin
			st_d = aout_pkg::ST_FAULT;
		end else begin
			st_d = aout_pkg::ST_RUN;
		end
	end

	always_comb begin
		unique case (st_d)
			aout_pkg::ST_OFF:   setpoint_d = `LVL_0;
			aout_pkg::ST_FAULT: setpoint_d = flt_lvl;
			aout_pkg::ST_RUN:   setpoint_d = link_mode ? remote_q : mapped;
		endcase
	end

	// Status events; a pending read clear never hides a same-cycle event
	wire map_run = (st_d == aout_pkg::ST_RUN) & ~link_mode;
	wire [3:0] ev;
	assign ev[`ST_CLAMP_LO] = map_run & below;
	assign ev[`ST_CLAMP_HI] = map_run & above;
	assign ev[`ST_FAULT_IN] = (st_d == aout_pkg::ST_FAULT) & (st_q != aout_pkg::ST_FAULT);
	assign ev[`ST_LINK_TMO] = lost & ~lost_q;
	wire [3:0] status_d = (rd_stat ? 4'h0 : status_q) | ev;

	// Ack lasts one cycle, so a held strobe is taken again in the cycle after the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// Read data stays zero outside the acknowledge cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_dat_o <= rd ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= `RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_q <= ctrl_wr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_q <= `RST_EXT;
		end else if (wr_ext) begin
			ext_q <= ext_wr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_lo_q <= `RST_IN_LO;
		end else if (wr_lo) begin
			in_lo_q <= lo_m[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_hi_q <= `RST_IN_HI;
		end else if (wr_hi) begin
			in_hi_q <= hi_m[15:0];
		end
	end

	// Timeouts above the maximum saturate there
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tmo_q <= `RST_TMO;
		end else if (wr_tmo) begin
			tmo_q <= tmo_wr;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remote_q <= `RST_REMOTE;
		end else if (wr_rem) begin
			remote_q <= rem_m[15:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_q <= `RST_MASK;
		end else if (wr_mask) begin
			mask_q <= mask_m[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= `RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	// Prescaler to whole seconds since the last frame
	always_ff @(posedge clk_i) begin
		if (rst_i | frame_rx_i) begin
			pre_q <= '0;
		end else begin
			pre_q <= sec_tick ? '0 : pre_q + 1'b1;
		end
	end

	// Saturates so long silence cannot wrap back to a short gap
	always_ff @(posedge clk_i) begin
		if (rst_i | frame_rx_i) begin
			secs_q <= 7'h00;
		end else if (sec_tick & (secs_q != `SECS_SAT)) begin
			secs_q <= secs_q + 7'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= aout_pkg::ST_OFF;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lost_q <= 1'b0;
		end else begin
			lost_q <= lost;
		end
	end

	// Hold fault level reads this register back, so the entry level persists
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			setpoint_o <= `LVL_0;
		end else begin
			setpoint_o <= setpoint_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_en_o <= 1'b0;
		end else begin
			out_en_o <= st_d != aout_pkg::ST_OFF;
		end
	end

	// Off mode never reports a fault
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_o <= 1'b0;
		end else begin
			fault_o <= st_d == aout_pkg::ST_FAULT;
		end
	end

	// Next status used, so a clearing read and a new event agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_d & mask_q);
		end
	end

endmodule : analog_output_setpoint_control

// ===== tb/aout_assertions.sv
// Concurrent checks on the ports of the analogue output setpoint block.
// Assumes a single clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module aout_assertions (
	input wire logic               clk_i,        // System clock
	input wire logic               rst_i,        // Synchronous reset
	input wire logic               wb_cyc_i,     // Bus cycle
	input wire logic               wb_stb_i,     // Bus strobe
	input wire logic               wb_we_i,      // Bus write enable
	input wire logic        [7:0]  wb_adr_i,     // Bus address
	input wire logic        [3:0]  wb_sel_i,     // Byte enables
	input wire logic        [31:0] wb_dat_i,     // Write data
	input wire logic        [31:0] wb_dat_o,     // Read data
	input wire logic               wb_ack_o,     // Acknowledge
	input wire logic signed [15:0] live_value_i, // Live value
	input wire logic signed [15:0] peak_value_i, // Held value
	input wire logic               critical_i,   // Critical level
	input wire logic               frame_rx_i,   // Frame pulse
	input wire logic        [15:0] setpoint_o,   // Setpoint
	input wire logic               out_en_o,     // Stage enable
	input wire logic               fault_o,      // Fault applied
	input wire logic               irq_o         // Interrupt
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not acknowledged next cycle");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside acknowledge");
	property p_unmapped;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h20 |=> wb_dat_o == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
	property p_off_zero;
		!out_en_o |-> setpoint_o == 16'h0000;
	endproperty
	a_off_zero: assert property (p_off_zero) else $error("disabled output not at minimum");
	property p_off_nofault;
		!out_en_o |-> !fault_o;
	endproperty
	a_off_nofault: assert property (p_off_nofault) else $error("fault applied while disabled");
	property p_crit_fault;
		(critical_i && out_en_o) ##1 (critical_i && out_en_o) |-> fault_o;
	endproperty
	a_crit_fault: assert property (p_crit_fault) else $error("critical input not forcing fault");
	property p_reset_vals;
		$fell(rst_i) |-> setpoint_o == 16'h0000 && !out_en_o && !fault_o && !irq_o && !wb_ack_o;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
endmodule : aout_assertions

bind analog_output_setpoint_control aout_assertions u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .live_value_i(live_value_i), .peak_value_i(peak_value_i),
	.critical_i(critical_i), .frame_rx_i(frame_rx_i), .setpoint_o(setpoint_o),
	.out_en_o(out_en_o), .fault_o(fault_o), .irq_o(irq_o)
);

// ===== tb/aout_stage_model.sv
// Behavioural analogue output stage fed by the setpoint block.
// Assumes setpoint in uA or mV and the same system clock.
`timescale 1ns/1ps
module aout_stage_model (
	input  wire logic        clk_i,      // System clock
	input  wire logic        rst_i,      // Synchronous reset
	input  wire logic [15:0] setpoint_i, // Requested level
	input  wire logic        en_i,       // Stage enabled
	output logic      [15:0] level_o     // Level driven at the terminals
);
	// Stage settles one cycle late; a disabled stage sinks to zero
	always_ff @(posedge clk_i) begin
		if (rst_i || !en_i) begin
			level_o <= 16'h0000;
		end else begin
			level_o <= setpoint_i;
		end
	end
endmodule : aout_stage_model

// ===== tb/testbench.sv
// Self-checking bench for the analogue output setpoint block.
// Assumes the map header on the include path; one second is shortened to ten cycles.
`timescale 1ns/1ps
`include "aout_map.svh"
module testbench;
	logic               clk_i, rst_i, cyc, stb, we, ack, crit, frame, en, fault, irq;
	logic        [7:0]  adr;
	logic        [3:0]  sel;
	logic        [31:0] dat, dat_o, r;
	logic signed [15:0] live, peak;
	logic        [15:0] setpoint, level;
	int                 failures, samples_checked, i, n;
	logic [15:0] mc [8] = '{16'h04, 16'h08, 16'h0E, 16'h12, 16'h16, 16'h1A, 16'h05, 16'h09};
	logic [15:0] me [8] = '{16'h1388, 16'h1F40, 16'h04E2, 16'h07D0, 16'h09C4, 16'h0FA0, 16'h0, 16'h1F40};
	logic [15:0] fc [11] = '{16'h08, 16'h28, 16'h48, 16'hA8, 16'hA9, 16'h36, 16'h56, 16'h76, 16'h96, 16'hB6, 16'h16};
	logic [15:0] fe [11] = '{16'h1F40, `LVL_22M1A, `LVL_3M4A, 16'h0, 16'h1F40, `LVL_11V, `LVL_5V5, `LVL_1V2,
		`LVL_0V6, 16'h0, 16'h09C4};
	logic [15:0] fn [11] = '{16'h1F40, 16'h1F40, 16'h1F40, 16'h1F40, 16'h1F40, 16'h09C4, 16'h09C4, 16'h09C4,
		16'h09C4, 16'h09C4, 16'h09C4};

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	analog_output_setpoint_control #(.SEC_CYCLES(10)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .live_value_i(live),
		.peak_value_i(peak), .critical_i(crit), .frame_rx_i(frame), .setpoint_o(setpoint),
		.out_en_o(en), .fault_o(fault), .irq_o(irq)
	);
	aout_stage_model stage (.clk_i(clk_i), .rst_i(rst_i), .setpoint_i(setpoint), .en_i(en), .level_o(level));

	task automatic test_done;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Holds the request until ack is sampled, then releases for at least one cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		r = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			failures++;
			$display("BAD %0t no acknowledge", $time);
			test_done();
		end
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		chk(r, e);
	endtask : rd

	task automatic sp(input logic [15:0] e);
		repeat (3) @(posedge clk_i);
		chk({16'h0, level}, {16'h0, e});
	endtask : sp

	task automatic pulse;
		frame <= 1'b1;
		@(posedge clk_i);
		frame <= 1'b0;
	endtask : pulse

	initial begin
		failures = 0;
		samples_checked = 0;
		{rst_i, cyc, stb, we, crit, frame, adr, sel, dat} = {1'b1, 49'h0};
		live = 16'sd250;
		peak = 16'sd750;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`A_CTRL, `RST_CTRL);
		rd(`A_IN_HI, {16'h0, `RST_IN_HI});
		rd(8'h3C, 32'h0);
		wr(`A_CTRL, 32'hFFFF_FE00);
		rd(`A_CTRL, 32'h0);
		wb(1'b1, `A_IN_HI, 32'h0000_FFFF, 4'h2);
		rd(`A_IN_HI, 32'h0000_FFE8);
		wr(`A_IN_HI, 32'h0000_03E8);
		for (i = 0; i < 8; i++) begin
			wr(`A_CTRL, {16'h0, mc[i]});
			sp(me[i]);
		end
		rd(`A_SETPT, 32'h0000_1F40);
		wr(`A_IN_LO, 32'h0000_03E8);
		wr(`A_IN_HI, 32'h0);
		sp(16'h3E80);
		wr(`A_IN_LO, 32'h0);
		wr(`A_IN_HI, 32'h0000_03E8);
		wr(`A_CTRL, 32'h108);
		sp(16'h3E80);
		// Clamping with 20 / 10 percent extension, then 99.9 percent written and cut to the limits of each kind
		wr(`A_CTRL, 32'h08);
		wr(`A_EXT, 32'h0064_00C8);
		wr(`A_MASK, 32'h3);
		live <= -16'sd500;
		sp(16'h0C80);
		chk(irq, 1'b1);
		rd(`A_STATUS, 32'h1);
		live <= 16'sd2000;
		sp(16'h55F0);
		wr(`A_EXT, 32'h03E7_03E7);
		sp(16'h5DAC);
		wr(`A_CTRL, 32'h1A);
		sp(16'h2AEE);
		live <= -16'sd500;
		sp(16'h0002);
		wr(`A_CTRL, 32'h08);
		sp(16'h0004);
		wr(`A_CTRL, 32'h09);
		sp(16'h0AF4);
		wr(`A_MASK, 32'h0);
		@(posedge clk_i);
		chk(irq, 1'b0);
		live <= 16'sd250;
		wr(`A_EXT, 32'h0);
		rd(`A_STATUS, 32'h3);
		rd(`A_STATUS, 32'h0);
		for (i = 0; i < 11; i++) begin
			wr(`A_CTRL, {16'h0, fc[i]});
			sp(fn[i]);
			crit <= 1'b1;
			sp(fe[i]);
			chk(fault, 1'b1);
			crit <= 1'b0;
			sp(fn[i]);
		end
		wr(`A_CTRL, 32'h20);
		crit <= 1'b1;
		sp(16'h0);
		chk({en, fault}, 2'b00);
		crit <= 1'b0;
		wr(`A_REMOTE, 32'h0000_1234);
		wr(`A_CTRL, 32'h3C);
		sp(16'h1234);
		repeat (60) @(posedge clk_i);
		chk(fault, 1'b0);
		wr(`A_TIMEOUT, 32'h78);
		rd(`A_TIMEOUT, {25'h0, `TMO_MAX_S});
		wr(`A_TIMEOUT, 32'h2);
		pulse();
		repeat (12) @(posedge clk_i);
		chk(fault, 1'b0);
		n = 0;
		while (fault !== 1'b1 && n < 30) begin
			@(posedge clk_i);
			n++;
		end
		chk(fault, 1'b1);
		if (fault !== 1'b1)
			test_done();
		sp(`LVL_22M1A);
		rd(`A_STATUS, 32'hC);
		pulse();
		sp(16'h1234);
		test_done();
	end
endmodule : testbench
